// file: rtl/epi_defines.vh
// constants shared by the encoder position init block
`ifndef EPI_DEFINES_VH
`define EPI_DEFINES_VH

`define EPI_PIM_NONE 3'h0
`define EPI_PIM_EVERY 3'h1
`define EPI_PIM_NEXT 3'h2
`define EPI_PIM_HOME1 3'h3
`define EPI_PIM_HOME2 3'h4
`define EPI_PIM_GEC 3'h5
`define EPI_PIM_MOD 3'h6
`define EPI_PIM_RSVD 3'h7

`define EPI_CCM_QUAD 2'h0
`define EPI_CCM_TMR_BIT 1

`define EPI_ADDR_CTRL 4'h0
`define EPI_ADDR_INIT 4'h1
`define EPI_ADDR_GEC 4'h2
`define EPI_ADDR_LEC 4'h3
`define EPI_ADDR_POSL 4'h4
`define EPI_ADDR_POSH 4'h5
`define EPI_ADDR_STAT 4'h6

`define EPI_CTRL_EN 15
`define EPI_CTRL_SIDL 13
`define EPI_CTRL_PIM_LO 10
`define EPI_CTRL_IMVB 9
`define EPI_CTRL_IMVA 8
`define EPI_CTRL_SWAP 7
`define EPI_CTRL_APOL 6
`define EPI_CTRL_BPOL 5
`define EPI_CTRL_CCM_LO 0

`define EPI_CTRL_RESET 16'h0000
`define EPI_ARM_NONE 2'h0
`define EPI_ARM_HOME 2'h1
`define EPI_ARM_IDX1 2'h2
`define EPI_CTRL_WMASK 16'hbfe3

`endif

// file: rtl/epi_sync.v
// two flip-flop synchroniser for a group of level inputs
`timescale 1ns/10ps
module epi_sync
#(
    parameter WIDTH = 4
)
(
    input wire clock,
    input wire sys_rst,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);

reg [WIDTH-1:0] meta_r;

always @(posedge clock)
begin
    if (sys_rst)
    begin
        meta_r <= {WIDTH{1'b0}};
        sync_out <= {WIDTH{1'b0}};
    end
    else
    begin
        meta_r <= async_in;
        sync_out <= meta_r;
    end
end

endmodule // epi_sync

// file: rtl/epi_quad.v
// quadrature phase decoder giving count enable and direction
`timescale 1ns/10ps
module epi_quad
(
    input wire clock,
    input wire sys_rst,
    input wire phase_a,
    input wire phase_b,
    output reg step,
    output reg up
);

reg [1:0] prev_r;
wire [1:0] cur;

assign cur = {phase_a, phase_b};

always @(posedge clock)
begin
    if (sys_rst)
    begin
        prev_r <= 2'h0;
        step <= 1'b0;
        up <= 1'b0;
    end
    else
    begin
        prev_r <= cur;
        step <= (^(prev_r ^ cur)) & 1'b1;
        up <= cur[1] ^ prev_r[0];
    end
end

endmodule // epi_quad

// file: rtl/epi_top.v
// encoder position counter with index and home initialisation
// Operation
// - mode 110: modulo count between bounds
// - mode 101: reset when equal compare value
// - mode 100: load on second index after home
// - mode 011: load on first index after home
// - mode 010: load on next index only
// - mode 001: reset on every index
// - mode 000: index leaves counter alone
// - phase b match level from its bit
// - phase a match level from its bit
// - timer modes ignore init mode field
// - index match acts only in quad mode, as its init mode sets
// - match uses swapped, inverted phases
// - idle stop clear keeps counting in idle
// - idle stop set halts in idle
// - disabled counters stop, registers stay usable
`timescale 1ns/10ps
`include "epi_defines.vh"
module epi_top
#(
    parameter CNT_W = 32
)
(
    input wire clock,
    input wire sys_rst,
    input wire encoder_phase_a,
    input wire encoder_phase_b,
    input wire index_in,
    input wire home_in,
    input wire idle_mode,
    input wire [3:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata,
    output reg [CNT_W-1:0] position_count
);

////////////////////////////////////////////////////////////////////////
// registers

reg [15:0] ctrl_r;
reg [CNT_W-1:0] init_r;
reg [CNT_W-1:0] gec_r;
reg [CNT_W-1:0] lec_r;
reg [1:0] arm_r;
reg [1:0] arm_nxt;
reg [CNT_W-1:0] pos_nxt;
reg armed_next_r;
reg armed_next_nxt;
reg [15:0] rdata_nxt;

wire counter_enable;
wire idle_stop;
wire [2:0] position_init_mode;
wire index_match_phase_b;
wire index_match_phase_a;
wire phase_swap;
wire phase_a_polarity;
wire phase_b_polarity;
wire [1:0] counter_config_mode;

assign counter_enable = ctrl_r[`EPI_CTRL_EN];
assign idle_stop = ctrl_r[`EPI_CTRL_SIDL];
assign position_init_mode = ctrl_r[`EPI_CTRL_PIM_LO+2:`EPI_CTRL_PIM_LO];
assign index_match_phase_b = ctrl_r[`EPI_CTRL_IMVB];
assign index_match_phase_a = ctrl_r[`EPI_CTRL_IMVA];
assign phase_swap = ctrl_r[`EPI_CTRL_SWAP];
assign phase_a_polarity = ctrl_r[`EPI_CTRL_APOL];
assign phase_b_polarity = ctrl_r[`EPI_CTRL_BPOL];
assign counter_config_mode = ctrl_r[`EPI_CTRL_CCM_LO+1:`EPI_CTRL_CCM_LO];

////////////////////////////////////////////////////////////////////////
// input synchronisation and edge detection

wire [3:0] sync_in;
reg [1:0] evt_prev_r;

epi_sync #(.WIDTH(4)) u_sync
(
    .clock(clock),
    .sys_rst(sys_rst),
    .async_in({home_in, index_in, encoder_phase_b, encoder_phase_a}),
    .sync_out(sync_in)
);

always @(posedge clock)
begin
    if (sys_rst)
        evt_prev_r <= 2'h0;
    else
        evt_prev_r <= sync_in[3:2];
end

wire phase_a_s;
wire phase_b_s;
wire index_s;
wire home_s;
wire index_evt;
wire home_evt;

assign phase_a_s = sync_in[0];
assign phase_b_s = sync_in[1];
assign index_s = sync_in[2];
assign home_s = sync_in[3];
// edges come from synchronised levels so a pulse acts only once
assign index_evt = index_s & ~evt_prev_r[0];
assign home_evt = home_s & ~evt_prev_r[1];

////////////////////////////////////////////////////////////////////////
// phase conditioning and index match

wire pa_swapped;
wire pb_swapped;
wire phase_a_c;
wire phase_b_c;
wire index_match;

assign pa_swapped = phase_swap ? phase_b_s : phase_a_s;
assign pb_swapped = phase_swap ? phase_a_s : phase_b_s;
assign phase_a_c = pa_swapped ^ phase_a_polarity;
assign phase_b_c = pb_swapped ^ phase_b_polarity;
assign index_match = (phase_a_c == index_match_phase_a)
    & (phase_b_c == index_match_phase_b);

wire step;
wire up;

// the decoder sees the conditioned phases: changing one polarity bit
// while enabled gives a false step, so change it with counting off
epi_quad u_quad
(
    .clock(clock),
    .sys_rst(sys_rst),
    .phase_a(phase_a_c),
    .phase_b(phase_b_c),
    .step(step),
    .up(up)
);

////////////////////////////////////////////////////////////////////////
// counter control

wire run;
wire timer_mode;
wire quad_mode;
wire idx_ok;
wire at_upper;
wire at_lower;

assign run = counter_enable & ~(idle_stop & idle_mode);
assign timer_mode = counter_config_mode[`EPI_CCM_TMR_BIT];
assign quad_mode = (counter_config_mode == `EPI_CCM_QUAD);
assign idx_ok = index_evt & index_match & quad_mode;
// bounds for the reset-on-compare and modulo modes
assign at_upper = (position_count == gec_r);
assign at_lower = (position_count == lec_r);

// one count up or down, wrapping at the counter width
function [CNT_W-1:0] count_step;
    input [CNT_W-1:0] val;
    input dir_up;
    begin
        if (dir_up)
            count_step = val + {{(CNT_W-1){1'b0}}, 1'b1};
        else
            count_step = val - {{(CNT_W-1){1'b0}}, 1'b1};
    end
endfunction

always @*
begin
    pos_nxt = position_count;
    arm_nxt = arm_r;
    armed_next_nxt = armed_next_r;
    if (timer_mode)
    begin
        pos_nxt = count_step(position_count, 1'b1);
    end
    else
    begin
        if (step)
        begin
            pos_nxt = count_step(position_count, up);
        end
        // index actions override this cycle's step
        case (position_init_mode)
        `EPI_PIM_NONE:
            pos_nxt = pos_nxt;
        `EPI_PIM_EVERY:
        begin
            if (idx_ok)
                pos_nxt = {CNT_W{1'b0}};
        end
        `EPI_PIM_NEXT:
        begin
            if (idx_ok && !armed_next_r)
            begin
                pos_nxt = init_r;
                armed_next_nxt = 1'b1;
            end
        end
        `EPI_PIM_HOME1:
        begin
            if (home_evt)
                arm_nxt = `EPI_ARM_HOME;
            else if (idx_ok && arm_r != `EPI_ARM_NONE)
            begin
                pos_nxt = init_r;
                arm_nxt = `EPI_ARM_NONE;
            end
        end
        `EPI_PIM_HOME2:
        begin
            // first index after home only advances the arm state
            if (home_evt)
                arm_nxt = `EPI_ARM_HOME;
            else if (idx_ok && arm_r == `EPI_ARM_HOME)
                arm_nxt = `EPI_ARM_IDX1;
            else if (idx_ok && arm_r == `EPI_ARM_IDX1)
            begin
                pos_nxt = init_r;
                arm_nxt = `EPI_ARM_NONE;
            end
        end
        `EPI_PIM_GEC:
        begin
            if (at_upper)
                pos_nxt = {CNT_W{1'b0}};
        end
        `EPI_PIM_MOD:
        begin
            // wrap only on a step across a bound
            if (step && up && at_upper)
                pos_nxt = lec_r;
            else if (step && !up && at_lower)
                pos_nxt = gec_r;
        end
        default:
            pos_nxt = pos_nxt;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////
// register bus and state update

// picks the low or high sixteen bits of a counter-wide value
function [15:0] half_sel;
    input [CNT_W-1:0] val;
    input hi;
    reg [31:0] wide;
    begin
        wide = 32'h0;
        wide[CNT_W-1:0] = val;
        half_sel = hi ? wide[31:16] : wide[15:0];
    end
endfunction

always @(posedge clock)
begin
    if (sys_rst)
    begin
        ctrl_r <= `EPI_CTRL_RESET;
        init_r <= {CNT_W{1'b0}};
        gec_r <= {CNT_W{1'b0}};
        lec_r <= {CNT_W{1'b0}};
        position_count <= {CNT_W{1'b0}};
        arm_r <= `EPI_ARM_NONE;
        armed_next_r <= 1'b0;
        reg_rdata <= 16'h0000;
    end
    else
    begin
        if (run)
        begin
            position_count <= pos_nxt;
            arm_r <= arm_nxt;
            armed_next_r <= armed_next_nxt;
        end
        if (reg_wr)
        begin
            case (reg_addr)
            `EPI_ADDR_CTRL:
            begin
                ctrl_r <= reg_wdata & `EPI_CTRL_WMASK;
                // an arming event in the same cycle wins over the clear
                armed_next_r <= run & armed_next_nxt & ~armed_next_r;
                if (run && home_evt && arm_nxt == `EPI_ARM_HOME)
                    arm_r <= `EPI_ARM_HOME;
                else
                    arm_r <= `EPI_ARM_NONE;
            end
            `EPI_ADDR_INIT:
                init_r[15:0] <= reg_wdata;
            `EPI_ADDR_GEC:
                gec_r[15:0] <= reg_wdata;
            `EPI_ADDR_LEC:
                lec_r[15:0] <= reg_wdata;
            `EPI_ADDR_POSL:
                position_count[15:0] <= reg_wdata;
            default:
                ctrl_r <= ctrl_r;
            endcase
        end
        reg_rdata <= rdata_nxt;
    end
end

////////////////////////////////////////////////////////////////////////
// read data: stands one cycle after the strobe, zero otherwise

always @*
begin
    rdata_nxt = 16'h0000;
    if (reg_rd)
    begin
        case (reg_addr)
        `EPI_ADDR_CTRL:
            rdata_nxt = ctrl_r;
        `EPI_ADDR_INIT:
            rdata_nxt = half_sel(init_r, 1'b0);
        `EPI_ADDR_GEC:
            rdata_nxt = half_sel(gec_r, 1'b0);
        `EPI_ADDR_LEC:
            rdata_nxt = half_sel(lec_r, 1'b0);
        `EPI_ADDR_POSL:
            rdata_nxt = half_sel(position_count, 1'b0);
        `EPI_ADDR_POSH:
            rdata_nxt = half_sel(position_count, 1'b1);
        `EPI_ADDR_STAT:
            rdata_nxt = {11'h000, armed_next_r, arm_r, index_match, run};
        default:
            rdata_nxt = 16'h0000;
        endcase
    end
end

endmodule // epi_top

// file: dv/epi_enc_model.sv
// encoder model: quadrature phases, index and home pulses
`timescale 1ns/10ps
module epi_enc_model
(
    input wire clock,
    input wire step_req,
    input wire step_up,
    input wire idx_req,
    input wire home_req,
    output wire phase_a,
    output wire phase_b,
    output wire index_out,
    output wire home_out
);
reg [1:0] st_r = 2'h0;
reg [2:0] ix_r = 3'h0;
reg [2:0] hm_r = 3'h0;
// phase a leads phase b when stepping up
assign phase_a = st_r[1] ^ st_r[0];
assign phase_b = st_r[1];
assign index_out = ix_r != 3'h0;
assign home_out = hm_r != 3'h0;
always @(posedge clock)
begin
    if (step_req)
        st_r <= st_r + (step_up ? 2'h1 : 2'h3);
    ix_r <= idx_req ? 3'h4 : ix_r - (ix_r != 3'h0);
    hm_r <= home_req ? 3'h4 : hm_r - (hm_r != 3'h0);
end
endmodule // epi_enc_model

// file: dv/epi_chk.sv
// assertions on the encoder position block ports
`timescale 1ns/10ps
module epi_chk
#(
    parameter CNT_W = 32
)
(
    input wire clock,
    input wire sys_rst,
    input wire encoder_phase_a,
    input wire encoder_phase_b,
    input wire index_in,
    input wire idle_mode,
    input wire [3:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [15:0] reg_rdata,
    input wire [CNT_W-1:0] position_count
);
reg [15:0] c_r;
reg [1:0] r_r;
wire en = c_r[15];
wire run = en & ~(c_r[13] & idle_mode);
wire pw = reg_wr & (reg_addr == 4'h4);
wire sa = c_r[7] ? encoder_phase_b : encoder_phase_a;
wire sb = c_r[7] ? encoder_phase_a : encoder_phase_b;
wire mt = (sa ^ c_r[6]) == c_r[8] && (sb ^ c_r[5]) == c_r[9];
wire tk = c_r[1] & run & (r_r == 2'h3) & ~pw;
////////////////////////////////////////////////////////////
always @(posedge clock)
begin
    if (sys_rst)
    begin
        c_r <= 16'h0000;
        r_r <= 2'h0;
    end
    else
    begin
        if (reg_wr && reg_addr == 4'h0)
            c_r <= reg_wdata & 16'hbfe3;
        r_r <= {r_r[0], run};
    end
end
////////////////////////////////////////////////////////////
default clocking dc @(posedge clock);
endclocking
default disable iff (sys_rst);
rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside slot");
rd_ctrl_a: assert property (reg_rd && reg_addr == 4'h0
    |=> reg_rdata == $past(c_r)) else $error("control readback");
posl_wr_a: assert property (pw
    |=> position_count[15:0] == $past(reg_wdata)) else $error("low write");
dis_hold_a: assert property (!en && !pw |=> $stable(position_count))
    else $error("count moved while disabled");
idle_halt_a: assert property (en && !run && r_r == 2'h0 && !pw
    |=> $stable(position_count)) else $error("count moved in idle");
tmr_step_a: assert property (tk
    |-> ##1 position_count == $past(position_count) + 1) else $error("timer");
idle_run_a: assert property (tk && idle_mode
    |=> position_count == $past(position_count) + 1) else $error("idle run");
idx_rst_a: assert property ($rose(index_in) && run && r_r == 2'h3
    && c_r[1:0] == 2'h0 && c_r[12:10] == 3'h1 && mt
    |-> ##[1:5] position_count == 0) else $error("index reset missing");
cover property (tk);
cover property (en && !run);
cover property ($rose(index_in) && mt && run);
endmodule // epi_chk
bind epi_top epi_chk #(.CNT_W(CNT_W)) chk_u (.clock(clock),
    .sys_rst(sys_rst), .encoder_phase_a(encoder_phase_a),
    .encoder_phase_b(encoder_phase_b), .index_in(index_in),
    .idle_mode(idle_mode), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .position_count(position_count));

// file: dv/tb_encoder_position_init.sv
// self-checking bench for the encoder position block
`timescale 1ns/10ps
module tb_encoder_position_init;
reg clock = 1'h0;
reg sys_rst = 1'h1;
reg idle_mode = 1'h0;
reg [3:0] reg_addr = 4'h0;
reg [15:0] reg_wdata = 16'h0000;
reg reg_wr = 1'h0;
reg reg_rd = 1'h0;
reg stp = 1'h0;
reg up = 1'h0;
reg ixq = 1'h0;
reg hmq = 1'h0;
wire pa;
wire pb;
wire ix;
wire hm;
wire [15:0] reg_rdata;
wire [31:0] position_count;
integer err_total = 0;
integer check_count = 0;
integer cyc = 0;
integer m;
reg [15:0] d;
reg [15:0] q;
reg [15:0] iv;
reg [2:0] sw;
reg ea;
reg eb;
////////////////////////////////////////////////////////////
epi_top #(.CNT_W(32)) dut_u (.clock(clock), .sys_rst(sys_rst),
    .encoder_phase_a(pa), .encoder_phase_b(pb), .index_in(ix),
    .home_in(hm), .idle_mode(idle_mode), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .position_count(position_count));
epi_enc_model enc_u (.clock(clock), .step_req(stp), .step_up(up),
    .idx_req(ixq), .home_req(hmq), .phase_a(pa), .phase_b(pb),
    .index_out(ix), .home_out(hm));
initial
begin
    forever #5 clock = ~clock;
end
always @(posedge clock)
begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
        err_total = err_total + 1;
        print_verdict;
    end
end
////////////////////////////////////////////////////////////
task print_verdict;
begin
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
        $display("Result: passed");
    else
        $display("Result: failed");
    $finish;
end
endtask
task chk(input [31:0] s, input [31:0] e);
begin
    check_count = check_count + 1;
    if (s !== e)
    begin
        err_total = err_total + 1;
        $display("unexpected %0t seen %h want %h", $time, s, e);
    end
end
endtask
task wr(input [3:0] a, input [15:0] v);
begin
    @(posedge clock);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clock);
    reg_wr <= 1'h0;
end
endtask
task rd(input [3:0] a);
begin
    @(posedge clock);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'h0;
    #1 q = reg_rdata;
end
endtask
task step(input u);
begin
    @(posedge clock);
    stp <= 1'h1;
    up <= u;
    @(posedge clock);
    stp <= 1'h0;
    repeat (8) @(posedge clock);
end
endtask
task ev(input h);
begin
    @(posedge clock);
    hmq <= h;
    ixq <= ~h;
    @(posedge clock);
    hmq <= 1'h0;
    ixq <= 1'h0;
    repeat (12) @(posedge clock);
end
endtask
////////////////////////////////////////////////////////////
initial
begin
    d = $urandom(32'ha85652c3);
    repeat (12) @(posedge clock);
    sys_rst <= 1'h0;
    rd(4'h0);
    chk(q, 0);
    rd(4'hf);
    chk(q, 0);
    d = $urandom;
    wr(4'h4, d);
    step(1'h1);
    ev(1'h0);
    chk(position_count, d);
    for (m = 0; m < 5; m = m + 1)
    begin
        sw = $urandom;
        iv = $urandom;
        ea = (sw[2] ? pb : pa) ^ sw[1];
        eb = (sw[2] ? pa : pb) ^ sw[0];
        wr(4'h0, {8'h00, sw, 5'h00});
        wr(4'h1, iv);
        wr(4'h4, d);
        wr(4'h0, {3'h4, m[2:0], eb ^ ~m[0], ea ^ m[0], sw, 5'h00});
        ev(1'h0);
        chk(position_count, d);
        wr(4'h0, {3'h4, m[2:0], eb, ea, sw, 5'h00});
        case (m)
        0: ev(1'h0);
        2:
        begin
            ev(1'h0);
            chk(position_count, iv);
            wr(4'h4, d);
            ev(1'h0);
        end
        3:
        begin
            ev(1'h0);
            chk(position_count, d);
            ev(1'h1);
            ev(1'h0);
        end
        4:
        begin
            ev(1'h1);
            ev(1'h0);
            chk(position_count, d);
            ev(1'h0);
        end
        default: ev(1'h0);
        endcase
        chk(position_count, m == 1 ? 0 : m > 2 ? iv : d);
    end
    wr(4'h0, 16'h0000);
    wr(4'h2, 16'h0005);
    wr(4'h4, 16'h0003);
    wr(4'h0, 16'h9400);
    step(1'h1);
    chk(position_count, 4);
    step(1'h1);
    chk(position_count, 0);
    wr(4'h3, 16'h0002);
    wr(4'h2, 16'h0004);
    wr(4'h0, 16'h9800);
    wr(4'h4, 16'h0004);
    step(1'h1);
    chk(position_count, 2);
    step(1'h0);
    chk(position_count, 4);
    idle_mode <= 1'h1;
    for (m = 2; m < 4; m = m + 1)
    begin
        wr(4'h4, 16'h0000);
        wr(4'h0, {6'h21, 8'h80, m[1:0]});
        rd(4'h4);
        d = q;
        ev(1'h0);
        rd(4'h4);
        chk(q, d + 16'h0010);
    end
    wr(4'h0, {6'h29, 8'h00, 2'h2});
    rd(4'h4);
    d = q;
    rd(4'h4);
    chk(q, d);
    print_verdict;
end
endmodule // tb_encoder_position_init
